// file: byte_to_q15.sv
// Widens one unsigned byte to a non-negative Q15 halfword
`timescale 1ns/1ns
`default_nettype none
module byte_to_q15 (
  input  wire logic [precision_expand_pkg::BYTE_W-1:0] i_byte,
  output logic      [precision_expand_pkg::HALF_W-1:0] o_q15
);
  import precision_expand_pkg::*;

  // ----------------------------------------------------------------------
  // Zero sign, byte, seven zero fraction bits; no rounding ever needed
  // ----------------------------------------------------------------------
  assign o_q15 = {1'b0, i_byte, {Q15_PAD_W{1'b0}}};
endmodule
`default_nettype wire

// file: fractional_precision_expander.sv
// Decode and datapath of the five precision-expand instructions
`timescale 1ns/1ns
`default_nettype none
module fractional_precision_expander #(
  parameter bit DSP_PRESENT = 1'b1
) (
  input  wire logic                                        i_clk_sys,
  input  wire logic                                        i_rst_n,
  input  wire logic                                        i_issue_valid,
  input  wire logic [precision_expand_pkg::INSTR_W-1:0]    i_instr,
  input  wire logic [precision_expand_pkg::DATA_W-1:0]     i_src_data,
  input  wire logic                                        i_dsp_enable,
  output logic                                             o_result_valid,
  output logic                                             o_wr_en,
  output logic [precision_expand_pkg::REG_ADDR_W-1:0]      o_wr_addr,
  output logic [precision_expand_pkg::DATA_W-1:0]          o_wr_data,
  output logic                                             o_exc_reserved,
  output logic                                             o_exc_dsp_disabled
);
  import precision_expand_pkg::*;

  // ----------------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------------
  wire logic [5:0]            major_field;
  wire logic [4:0]            src_a_field;
  wire logic [4:0]            dest_field;
  wire logic [4:0]            sub_field;
  wire logic [5:0]            func_field;

  assign major_field = i_instr[MAJOR_MSB:MAJOR_LSB];
  assign src_a_field = i_instr[SRC_A_MSB:SRC_A_LSB];
  assign dest_field  = i_instr[DEST_MSB:DEST_LSB];
  assign sub_field   = i_instr[SUB_MSB:SUB_LSB];
  assign func_field  = i_instr[FUNC_MSB:FUNC_LSB];

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Other sub codes of this group belong to neighbouring slices, so they
  // are not claimed here and raise nothing from this block.
  wire logic                  group_hit;
  wire logic                  is_half;
  wire logic                  is_lpair;
  wire logic                  is_lalt;
  wire logic                  is_rpair;
  wire logic                  is_ralt;
  wire logic                  is_ours;
  wire logic                  src_a_bad;
  expand_op_t                 op_kind;

  assign group_hit = i_issue_valid
                   && (major_field == EXTENDED_MAJOR_OPCODE)
                   && (func_field == EXPAND_FUNCTION_GROUP);
  assign is_half   = group_hit && (sub_field == SUB_RIGHT_HALF_TO_WORD);
  assign is_lpair  = group_hit && (sub_field == SUB_LEFT_BYTE_PAIR);
  assign is_lalt   = group_hit && (sub_field == SUB_LEFT_ALT_BYTES);
  assign is_rpair  = group_hit && (sub_field == SUB_RIGHT_BYTE_PAIR);
  assign is_ralt   = group_hit && (sub_field == SUB_RIGHT_ALT_BYTES);
  assign is_ours   = is_half || is_lpair || is_lalt || is_rpair || is_ralt;
  assign src_a_bad = (src_a_field != SRC_A_ZERO);

  assign op_kind = is_half  ? OP_RIGHT_HALF_TO_WORD :
                   is_lpair ? OP_LEFT_BYTE_PAIR     :
                   is_lalt  ? OP_LEFT_ALT_BYTES     :
                   is_rpair ? OP_RIGHT_BYTE_PAIR    :
                   is_ralt  ? OP_RIGHT_ALT_BYTES    : OP_NONE;

  // ----------------------------------------------------------------------
  // Exceptions, from instruction bits and enable only
  // ----------------------------------------------------------------------
  // Operand data never enters these terms: no overflow, no saturation.
  wire logic                  take_reserved;
  wire logic                  take_disabled;
  wire logic                  do_write;

  assign take_reserved = is_ours && (src_a_bad || !DSP_PRESENT);
  assign take_disabled = is_ours && !take_reserved
                       && !i_dsp_enable;
  assign do_write      = is_ours && !take_reserved && !take_disabled
                       && (dest_field != GENERAL_REG_ZERO);

  // ----------------------------------------------------------------------
  // Byte lane selection for the two result halfwords
  // ----------------------------------------------------------------------
  wire logic [BYTE_W-1:0]     b3;
  wire logic [BYTE_W-1:0]     b2;
  wire logic [BYTE_W-1:0]     b1;
  wire logic [BYTE_W-1:0]     b0;
  wire logic [BYTE_W-1:0]     lane_byte [LANES];
  wire logic [HALF_W-1:0]     lane_q15  [LANES];

  assign b3 = i_src_data[BYTE3_LSB +: BYTE_W];
  assign b2 = i_src_data[BYTE2_LSB +: BYTE_W];
  assign b1 = i_src_data[BYTE1_LSB +: BYTE_W];
  assign b0 = i_src_data[BYTE0_LSB +: BYTE_W];

  // Lane 1 feeds the upper halfword, lane 0 the lower
  assign lane_byte[1] = (is_lpair || is_lalt) ? b3 :
                        is_rpair              ? b1 : b2;
  assign lane_byte[0] = is_lpair              ? b2 :
                        is_lalt               ? b1 : b0;

  // One widener per lane
  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      byte_to_q15 u_widen (
        .i_byte (lane_byte[g]),
        .o_q15  (lane_q15[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Result word
  // ----------------------------------------------------------------------
  wire logic [DATA_W-1:0]     half_word;
  wire logic [DATA_W-1:0]     byte_word;
  wire logic [DATA_W-1:0]     result_next;

  assign half_word   = {i_src_data[HALF_W-1:0], HALF_ZERO};
  assign byte_word   = {lane_q15[1], lane_q15[0]};
  assign result_next = is_half ? half_word : byte_word;

  // ----------------------------------------------------------------------
  // Writeback stage: one cycle from issue to answer
  // ----------------------------------------------------------------------
  logic                       valid_reg;
  logic                       wr_en_reg;
  logic [REG_ADDR_W-1:0]      wr_addr_reg;
  logic [DATA_W-1:0]          wr_data_reg;
  logic                       reserved_reg;
  logic                       disabled_reg;

  // Control flags follow each issue slot
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      valid_reg    <= 1'b0;
      wr_en_reg    <= 1'b0;
      reserved_reg <= 1'b0;
      disabled_reg <= 1'b0;
    end else begin
      valid_reg    <= is_ours;
      wr_en_reg    <= do_write;
      reserved_reg <= take_reserved;
      disabled_reg <= take_disabled;
    end
  end

  // Data holds between our instructions to save toggling
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_addr_reg <= GENERAL_REG_ZERO;
      wr_data_reg <= DATA_RESET;
    end else if (is_ours) begin
      wr_addr_reg <= dest_field;
      wr_data_reg <= result_next;
    end
  end

  assign o_result_valid     = valid_reg;
  assign o_wr_en            = wr_en_reg;
  assign o_wr_addr          = wr_addr_reg;
  assign o_wr_data          = wr_data_reg;
  assign o_exc_reserved     = reserved_reg;
  assign o_exc_dsp_disabled = disabled_reg;

  // ----------------------------------------------------------------------
  // Checking helpers: previous cycle's operand, kind and enable
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0]          chk_src_reg;
  expand_op_t                 chk_kind_reg;
  logic                       chk_en_reg;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chk_src_reg  <= DATA_RESET;
      chk_kind_reg <= OP_NONE;
      chk_en_reg   <= 1'b0;
    end else begin
      chk_src_reg  <= i_src_data;
      chk_kind_reg <= op_kind;
      chk_en_reg   <= i_dsp_enable;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_issue_ok;
    is_ours && !src_a_bad && i_dsp_enable && DSP_PRESENT;
  endsequence

  sequence s_wb_done;
    o_result_valid && !o_exc_reserved && !o_exc_dsp_disabled;
  endsequence

  property p_half_word;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_result_valid && chk_kind_reg == OP_RIGHT_HALF_TO_WORD
      |-> o_wr_data[31:16] == chk_src_reg[15:0]
       && o_wr_data[15:0] == HALF_ZERO;
  endproperty
  a_half_word: assert property (p_half_word)
    else $error("half to word result wrong");

  property p_left_pair;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_result_valid && chk_kind_reg == OP_LEFT_BYTE_PAIR
      |-> o_wr_data == {1'b0, chk_src_reg[31:24], 7'h00,
                        1'b0, chk_src_reg[23:16], 7'h00};
  endproperty
  a_left_pair: assert property (p_left_pair)
    else $error("left pair result wrong");

  property p_left_alt;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_result_valid && chk_kind_reg == OP_LEFT_ALT_BYTES
      |-> o_wr_data == {1'b0, chk_src_reg[31:24], 7'h00,
                        1'b0, chk_src_reg[15:8], 7'h00};
  endproperty
  a_left_alt: assert property (p_left_alt)
    else $error("left alternate result wrong");

  property p_right_pair;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_result_valid && chk_kind_reg == OP_RIGHT_BYTE_PAIR
      |-> o_wr_data == {1'b0, chk_src_reg[15:8], 7'h00,
                        1'b0, chk_src_reg[7:0], 7'h00};
  endproperty
  a_right_pair: assert property (p_right_pair)
    else $error("right pair result wrong");

  property p_right_alt;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_result_valid && chk_kind_reg == OP_RIGHT_ALT_BYTES
      |-> o_wr_data == {1'b0, chk_src_reg[23:16], 7'h00,
                        1'b0, chk_src_reg[7:0], 7'h00};
  endproperty
  a_right_alt: assert property (p_right_alt)
    else $error("right alternate result wrong");

  property p_q15_form;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_result_valid && chk_kind_reg != OP_RIGHT_HALF_TO_WORD
      |-> !o_wr_data[31] && !o_wr_data[15]
       && o_wr_data[22:16] == 7'h00 && o_wr_data[6:0] == 7'h00;
  endproperty
  a_q15_form: assert property (p_q15_form)
    else $error("byte lane not in Q15 form");

  property p_decode;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    s_issue_ok |=> s_wb_done;
  endproperty
  a_decode: assert property (p_decode)
    else $error("valid expand not completed next cycle");

  property p_no_data_exc;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_result_valid && chk_en_reg && DSP_PRESENT && !o_exc_reserved
      |-> !o_exc_dsp_disabled;
  endproperty
  a_no_data_exc: assert property (p_no_data_exc)
    else $error("exception without a decode cause");

  property p_exc_no_write;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_exc_reserved || o_exc_dsp_disabled)
      |-> !o_wr_en && o_result_valid
       && !(o_exc_reserved && o_exc_dsp_disabled);
  endproperty
  a_exc_no_write: assert property (p_exc_no_write)
    else $error("write or double exception on trap");

  property p_reg_zero;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    s_issue_ok ##1 (o_wr_addr == GENERAL_REG_ZERO) |-> !o_wr_en;
  endproperty
  a_reg_zero: assert property (p_reg_zero)
    else $error("write to register zero");

  // Foreign codes belong to other slices, so nothing may answer them
  property p_foreign_quiet;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !is_ours |=> !o_result_valid && !o_wr_en
              && !o_exc_reserved && !o_exc_dsp_disabled;
  endproperty
  a_foreign_quiet: assert property (p_foreign_quiet)
    else $error("unclaimed instruction answered");

endmodule
`default_nettype wire

// file: fractional_precision_expander_tb.sv
// Self-checking bench for the fractional precision expander
`timescale 1ns/1ns
`default_nettype none
module fractional_precision_expander_tb;
  import precision_expand_pkg::*;
  logic        i_clk_sys, i_rst_n, i_issue_valid, i_dsp_enable;
  logic        o_result_valid, o_wr_en, o_exc_reserved, o_exc_dsp_disabled;
  logic        ld_en, held_ok;
  logic        nd_valid, nd_wr_en, nd_res, nd_dis;
  logic [4:0]  o_wr_addr, ld_addr, exp_addr;
  logic [31:0] i_instr, src_data, o_wr_data, ld_data, exp_data, seed, r;
  int          bad_count, n_tests, i, k;
  logic [4:0]  codes [5] = '{5'h0d, 5'h04, 5'h06, 5'h05, 5'h07};

  fractional_precision_expander #(.DSP_PRESENT(1'b1)) u_dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_issue_valid(i_issue_valid), .i_instr(i_instr),
    .i_src_data(src_data), .i_dsp_enable(i_dsp_enable),
    .o_result_valid(o_result_valid), .o_wr_en(o_wr_en),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_exc_reserved(o_exc_reserved),
    .o_exc_dsp_disabled(o_exc_dsp_disabled));

  // Same slice built without the extension: every claim must trap
  fractional_precision_expander #(.DSP_PRESENT(1'b0)) u_dut_no_ext (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_issue_valid(i_issue_valid), .i_instr(i_instr),
    .i_src_data(src_data), .i_dsp_enable(i_dsp_enable),
    .o_result_valid(nd_valid), .o_wr_en(nd_wr_en),
    .o_wr_addr(), .o_wr_data(),
    .o_exc_reserved(nd_res), .o_exc_dsp_disabled(nd_dis));

  pipeline_reg_model u_pipe (
    .i_clk_sys(i_clk_sys), .i_wr_en(o_wr_en), .i_wr_addr(o_wr_addr),
    .i_wr_data(o_wr_data), .i_load_en(ld_en), .i_load_addr(ld_addr),
    .i_load_data(ld_data), .i_rd_addr(i_instr[20:16]),
    .o_rd_data(src_data));

  // --------------------------------------------------------------------
  // Clock, helpers and reference model
  // --------------------------------------------------------------------
  // 100 MHz core clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [15:0] q15(input logic [7:0] b);
    return {1'b0, b, 7'h00};
  endfunction

  function automatic logic [31:0] mk(input logic [4:0] sub, pad, src, dst);
    return {6'h1f, pad, src, dst, sub, 6'h12};
  endfunction

  task automatic chk_bit(input logic got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One issue cycle; the operand is what the pipeline really supplied,
  // so read-after-write hazards need no modelling here
  task automatic step(input logic v, input logic [31:0] ins, input logic en);
    logic hit, res, dis;
    logic [31:0] s, d;
    logic [4:0] sub;
    i_issue_valid = v;
    i_instr = ins;
    i_dsp_enable = en;
    #1;
    s = src_data;
    sub = ins[10:6];
    hit = v && ins[31:26] == 6'h1f && ins[5:0] == 6'h12 &&
          (sub == 5'h0d || sub inside {[5'h04:5'h07]});
    res = hit && ins[25:21] != 5'h00;
    dis = hit && !res && !en;
    case (sub)
      5'h0d: d = {s[15:0], 16'h0000};
      5'h04: d = {q15(s[31:24]), q15(s[23:16])};
      5'h06: d = {q15(s[31:24]), q15(s[15:8])};
      5'h05: d = {q15(s[15:8]), q15(s[7:0])};
      default: d = {q15(s[23:16]), q15(s[7:0])};
    endcase
    if (hit && !res && !dis) begin
      exp_addr = ins[15:11];
      exp_data = d;
      held_ok = 1'b1;
    end else if (hit) begin
      held_ok = 1'b0;
    end
    @(posedge i_clk_sys);
    #1;
    chk_bit(o_result_valid, hit, "valid");
    chk_bit(o_exc_reserved, res, "reserved");
    chk_bit(o_exc_dsp_disabled, dis, "disabled");
    chk_bit(o_wr_en, hit && !res && !dis && ins[15:11] != 5'h00,
            "wr_en");
    chk_bit(nd_valid && nd_res, hit, "no ext reserved");
    chk_bit(nd_wr_en || nd_dis, 1'b0, "no ext write");
    if (held_ok) begin
      chk_word({27'h0, o_wr_addr}, {27'h0, exp_addr}, "addr");
      chk_word(o_wr_data, exp_data,
               "data");
    end
  endtask

  // Reset for two cycles, then one idle cycle while release settles
  task automatic do_reset;
    i_rst_n = 1'b0;
    i_issue_valid = 1'b0;
    #1;
    chk_word({23'h0, o_result_valid, o_wr_en, o_exc_reserved,
              o_exc_dsp_disabled, o_wr_addr}, 32'h0000_0000, "rst ctl");
    chk_word(o_wr_data, 32'h0000_0000, "rst data");
    repeat (2) @(posedge i_clk_sys);
    #1;
    i_rst_n = 1'b1;
    exp_addr = 5'h00;
    exp_data = 32'h0000_0000;
    held_ok = 1'b1;
    step(1'b0, 32'h0000_0000, 1'b1);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Hang guard far above the roughly 480 cycles the scenarios take
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    bad_count++;
    finish_test();
  end

  initial begin
    seed = 32'h6997_1606;
    bad_count = 0;
    n_tests = 0;
    i_instr = 32'h0000_0000;
    i_dsp_enable = 1'b1;
    ld_en = 1'b0;
    ld_addr = 5'h00;
    ld_data = 32'h0000_0000;
    do_reset();
    // Operands: all ones, all zeros, the rest random
    for (i = 1; i < 32; i++) begin
      ld_en = 1'b1;
      ld_addr = i[4:0];
      ld_data = (i == 1) ? 32'hffff_ffff : (i == 2) ? 32'h0 : $random(seed);
      step(1'b0, $random(seed), 1'b1);
    end
    ld_en = 1'b0;
    $display("test preload done");
    // Every code, operands all ones, all zeros and one random, issued back to back
    for (k = 0; k < 5; k++) begin
      for (i = 1; i < 4; i++) begin
        step(1'b1, mk(codes[k], 5'h00, i[4:0], 5'(4 + k)), 1'b1);
      end
    end
    $display("test codes done");
    // Refusals: register zero, reserved, disabled, both, foreign codes
    for (k = 0; k < 5; k++) begin
      step(1'b1, mk(codes[k], 5'h00, 5'h01, 5'h00), 1'b1);
      step(1'b1, mk(codes[k], 5'h01, 5'h02, 5'h09), 1'b1);
      step(1'b1, mk(codes[k], 5'h00, 5'h03, 5'h0a), 1'b0);
      step(1'b1, mk(codes[k], 5'h1f, 5'h01, 5'h0b), 1'b0);
    end
    step(1'b1, mk(5'h04, 5'h00, 5'h01, 5'h0c) ^ 32'h0400_0000, 1'b1);
    step(1'b1, mk(5'h04, 5'h00, 5'h01, 5'h0c) ^ 32'h0000_0001, 1'b1);
    step(1'b1, mk(5'h0c, 5'h00, 5'h01, 5'h0c), 1'b1);
    step(1'b1, mk(5'h1c, 5'h00, 5'h01, 5'h0c), 1'b1);
    step(1'b0, mk(5'h04, 5'h00, 5'h01, 5'h0c), 1'b1);
    $display("test refuse done");
    // Random mix; results feed back as later operands
    for (i = 0; i < 400; i++) begin
      r = $random(seed);
      step(r[7:0] != 8'h00,
           (r[3:0] == 4'h0) ? $random(seed) :
           mk(codes[r[11:9] % 5], (r[14:12] == 3'h0) ? r[19:15] : 5'h00,
              r[24:20], r[29:25]),
           r[31:30] != 2'h0);
    end
    $display("test random done");
    // Reset in mid-run, then work resumes
    step(1'b1, mk(5'h06, 5'h00, 5'h01, 5'h0d), 1'b1);
    do_reset();
    step(1'b1, mk(5'h07, 5'h00, 5'h01, 5'h0e), 1'b1);
    $display("test reset done");
    finish_test();
  end
endmodule
`default_nettype wire

// file: pipeline_reg_model.sv
// Register file of the surrounding pipeline, facing the expand slice
`timescale 1ns/1ns
`default_nettype none
module pipeline_reg_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_wr_en,
  input  wire logic [4:0]  i_wr_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic        i_load_en,
  input  wire logic [4:0]  i_load_addr,
  input  wire logic [31:0] i_load_data,
  input  wire logic [4:0]  i_rd_addr,
  output logic      [31:0] o_rd_data
);
  logic [31:0] regs [32];

  // Bench preload wins over a retired result in the same cycle
  always @(posedge i_clk_sys) begin
    if (i_load_en) begin
      regs[i_load_addr] <= i_load_data;
    end else if (i_wr_en) begin
      regs[i_wr_addr] <= i_wr_data;
    end
  end

  // Operand read; register zero reads zero so a stray write never leaks
  assign o_rd_data = (i_rd_addr == 5'h00) ? 32'h0000_0000
                                          : regs[i_rd_addr];
endmodule
`default_nettype wire

// file: precision_expand_pkg.sv
// Package: instruction fields, codes and data layout of the expand slice
package precision_expand_pkg;

  // ----------------------------------------------------------------------
  // Instruction word fields
  // ----------------------------------------------------------------------
  localparam int          INSTR_W           = 32;
  localparam int          REG_ADDR_W        = 5;
  localparam int          MAJOR_MSB         = 31;
  localparam int          MAJOR_LSB         = 26;
  localparam int          SRC_A_MSB         = 25;
  localparam int          SRC_A_LSB         = 21;
  localparam int          DEST_MSB          = 15;
  localparam int          DEST_LSB          = 11;
  localparam int          SUB_MSB           = 10;
  localparam int          SUB_LSB           = 6;
  localparam int          FUNC_MSB          = 5;
  localparam int          FUNC_LSB          = 0;

  // ----------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------
  localparam logic [5:0]  EXTENDED_MAJOR_OPCODE   = 6'h1f;
  localparam logic [5:0]  EXPAND_FUNCTION_GROUP   = 6'h12;
  localparam logic [4:0]  SRC_A_ZERO              = 5'h00;
  localparam logic [4:0]  GENERAL_REG_ZERO        = 5'h00;
  localparam logic [4:0]  SUB_RIGHT_HALF_TO_WORD  = 5'h0d;
  localparam logic [4:0]  SUB_LEFT_BYTE_PAIR      = 5'h04;
  localparam logic [4:0]  SUB_LEFT_ALT_BYTES      = 5'h06;
  localparam logic [4:0]  SUB_RIGHT_BYTE_PAIR     = 5'h05;
  localparam logic [4:0]  SUB_RIGHT_ALT_BYTES     = 5'h07;

  // ----------------------------------------------------------------------
  // Data layout
  // ----------------------------------------------------------------------
  localparam int          DATA_W            = 32;
  localparam int          HALF_W            = 16;
  localparam int          BYTE_W            = 8;
  localparam int          Q15_PAD_W         = 7;
  localparam int          LANES             = 2;
  localparam int          BYTE0_LSB         = 0;
  localparam int          BYTE1_LSB         = 8;
  localparam int          BYTE2_LSB         = 16;
  localparam int          BYTE3_LSB         = 24;
  localparam logic [31:0] DATA_RESET        = 32'h0000_0000;
  localparam logic [15:0] HALF_ZERO         = 16'h0000;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_RIGHT_HALF_TO_WORD,
    OP_LEFT_BYTE_PAIR,
    OP_LEFT_ALT_BYTES,
    OP_RIGHT_BYTE_PAIR,
    OP_RIGHT_ALT_BYTES
  } expand_op_t;

endpackage
